// ===== pin_sampler.sv
// synchroniser and edge finder for the serial test pins
`default_nettype none
module pin_sampler (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw pins
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  // events
  scan_if.src ev
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic tck_d;
  } samp_t;
  samp_t st_reg, st_next;
  // pulled-up pins reset to one so an open pin reads high
  always_comb begin
    st_next = st_reg;
    st_next.s1 = {tck_pin, tms_pin, tdi_pin};
    st_next.s2 = st_reg.s1;
    st_next.tck_d = st_reg.s2[2];
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{s1: 3'h3, s2: 3'h3, tck_d: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign ev.rise = st_reg.s2[2] & ~st_reg.tck_d; // RULE5
  assign ev.fall = ~st_reg.s2[2] & st_reg.tck_d;
  assign ev.mode = st_reg.s2[1];
  assign ev.din = st_reg.s2[0];
endmodule // pin_sampler
`default_nettype wire

// ===== scan_ctl_model.sv
// behavioural board-test controller on the serial test pins
`default_nettype none
module scan_ctl_model (
  // test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock parked low outside frames; mode and data rest at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 160 ns test clock period; data out is read just before the rise, as a real tester does
  task automatic step(input logic m, input logic d, output logic q, output logic oe_n);
    tms = m;
    tdi = d;
    #80;
    q = tdo_o;
    oe_n = tdo_oe_n;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask
endmodule // scan_ctl_model
`default_nettype wire

// ===== scan_if.sv
// interface carrying the edge events from the pin sampler to the port logic
`default_nettype none
interface scan_if;
  logic rise;
  logic fall;
  logic mode;
  logic din;
  modport src (output rise, output fall, output mode, output din);
  modport dst (input rise, input fall, input mode, input din);
endinterface
`default_nettype wire

// ===== scan_pkg.sv
// package of constants and types for the boundary-scan test port
`default_nettype none
package scan_pkg;
  // ----------------------------------------
  // controller states, one-hot
  // ----------------------------------------
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;
  // ----------------------------------------
  // widths and defaults
  // ----------------------------------------
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int CHAIN_LEN = 109;
  localparam int OE_CELL = 108;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_IDCODE = 3'h1;
  localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] OP_SAMPLE = 3'h4;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  // arbitrary identification value, not a real maker code
  localparam logic [31:0] ID_VALUE = 32'h0000_0001;
  localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ===== scan_tap.sv
// boundary-scan test access port controller with its scan registers
// Function
// [RULE1] standard sixteen-state controller on mode select
// [RULE2] unused port: clock held low, output open
// [RULE3] data and mode inputs read high open
// [RULE4] power-up starts in reset, memory undisturbed
// [RULE5] sample on rising, drive on falling
// [RULE6] one register in path, chosen by instruction
// [RULE7] shift in at msb, out lsb
// [RULE8] output driven only in shift states
// [RULE9] five high mode edges reach reset
// [RULE10] port reset leaves memory operation alone
// [RULE11] internal power-up reset, output starts floating
// [RULE12] three-bit instruction register loaded serially
// [RULE13] identification instruction after any reset
// [RULE14] capture-instruction loads 01 in low bits
// [RULE15] one-bit bypass, cleared on capture
// [RULE16] chain holds one cell per ball
// [RULE17] boundary chain captures pins and shifts
// [RULE18] identification code captured then shifted
// [RULE19] reserved codes never loaded by tester
// [RULE20] new instruction acts at update-instruction
// [RULE21] sample-z floats memory output bus
// [RULE22] sample/preload snapshots, preload reaches latches
// [RULE23] cell 108 gates bus under external test
// [RULE24] bypass instruction selects bypass bit
// [RULE25] opcodes, code and length are parameters
`default_nettype none
module scan_tap import scan_pkg::*; #(
  parameter int CHAIN = scan_pkg::CHAIN_LEN, // RULE25
  parameter int OE_BIT = scan_pkg::OE_CELL,
  parameter logic [31:0] ID_CODE = scan_pkg::ID_VALUE,
  parameter logic [2:0] CODE_EXTEST = scan_pkg::OP_EXTEST,
  parameter logic [2:0] CODE_IDCODE = scan_pkg::OP_IDCODE,
  parameter logic [2:0] CODE_SAMPLE_Z = scan_pkg::OP_SAMPLE_Z,
  parameter logic [2:0] CODE_SAMPLE = scan_pkg::OP_SAMPLE,
  parameter logic [2:0] CODE_BYPASS = scan_pkg::OP_BYPASS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe_n,
  // pin ring
  input wire logic [CHAIN-1:0] ring_in,
  output logic [CHAIN-1:0] ring_out,
  output logic ring_drive,
  output logic qbus_float
);
  import scan_pkg::*;
  // latches come out of reset all low except the bus enable cell
  localparam logic [CHAIN-1:0] LAT_RST = CHAIN'(1) << OE_BIT;
  if (CHAIN < 2 || OE_BIT < 0 || OE_BIT >= CHAIN) begin : g_bad_size
    $error("scan_tap: chain length or enable cell out of range");
  end

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  scan_if ev ();
  // open pins: pull-ups are outside the core, the sampler resets mode and data high
  pin_sampler u_samp ( // RULE3
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tck_pin(tck), // RULE2
    .tms_pin(tms),
    .tdi_pin(tdi),
    .ev(ev)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    tap_state_t state;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [CHAIN-1:0] bs_sh;
    logic [CHAIN-1:0] bs_lat;
    logic tdo;
    logic oe_n;
  } tap_t;
  tap_t r_reg, r_next;

  logic sel_bs;
  logic sel_id;
  logic sel_byp;
  logic ser_out;

  always_comb begin
    sel_bs = (r_reg.ir == CODE_EXTEST) || (r_reg.ir == CODE_SAMPLE) || (r_reg.ir == CODE_SAMPLE_Z); // RULE6
    sel_id = (r_reg.ir == CODE_IDCODE);
    // reserved codes fall to bypass so the path keeps a defined length
    sel_byp = !sel_bs && !sel_id; // RULE24 RULE19
    if (r_reg.state == ST_SHIFT_IR) begin
      ser_out = r_reg.ir_sh[0]; // RULE7
    end else if (sel_bs) begin
      ser_out = r_reg.bs_sh[0];
    end else if (sel_id) begin
      ser_out = r_reg.id_sh[0];
    end else begin
      ser_out = r_reg.byp;
    end
  end

  // ----------------------------------------
  // controller and registers
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    if (ev.rise) begin // RULE5
      case (r_reg.state) // RULE1
        ST_RESET: r_next.state = ev.mode ? ST_RESET : ST_IDLE;
        ST_IDLE: r_next.state = ev.mode ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: r_next.state = ev.mode ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: r_next.state = ev.mode ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: r_next.state = ev.mode ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: r_next.state = ev.mode ? ST_UPD_DR : ST_PAUSE_DR;
        ST_PAUSE_DR: r_next.state = ev.mode ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: r_next.state = ev.mode ? ST_UPD_DR : ST_SHIFT_DR;
        ST_UPD_DR: r_next.state = ev.mode ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: r_next.state = ev.mode ? ST_RESET : ST_CAP_IR; // RULE9
        ST_CAP_IR: r_next.state = ev.mode ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: r_next.state = ev.mode ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: r_next.state = ev.mode ? ST_UPD_IR : ST_PAUSE_IR;
        ST_PAUSE_IR: r_next.state = ev.mode ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: r_next.state = ev.mode ? ST_UPD_IR : ST_SHIFT_IR;
        ST_UPD_IR: r_next.state = ev.mode ? ST_SEL_DR : ST_IDLE;
        default: r_next.state = ST_RESET;
      endcase
      case (r_reg.state)
        ST_CAP_IR: begin
          r_next.ir_sh = {r_reg.ir_sh[IR_W-1:2], IR_CAPTURE}; // RULE14
        end
        ST_SHIFT_IR: begin
          r_next.ir_sh = {ev.din, r_reg.ir_sh[IR_W-1:1]}; // RULE12 RULE7
        end
        ST_UPD_IR: begin
          r_next.ir = r_reg.ir_sh; // RULE20
        end
        ST_CAP_DR: begin
          if (sel_bs) begin
            r_next.bs_sh = ring_in; // RULE17 RULE22 RULE16
          end else if (sel_id) begin
            r_next.id_sh = ID_CODE; // RULE18
          end else if (sel_byp) begin
            r_next.byp = 1'b0; // RULE15
          end
        end
        ST_SHIFT_DR: begin
          if (sel_bs) begin
            r_next.bs_sh = {ev.din, r_reg.bs_sh[CHAIN-1:1]}; // RULE7
          end else if (sel_id) begin
            r_next.id_sh = {ev.din, r_reg.id_sh[ID_W-1:1]};
          end else if (sel_byp) begin
            r_next.byp = ev.din; // RULE24
          end
        end
        ST_UPD_DR: begin
          if (sel_bs) begin
            r_next.bs_lat = r_reg.bs_sh; // RULE22
          end
        end
        default: begin
        end
      endcase
      // every entry into reset restores the instruction, not only the first rise spent there
      if (r_next.state == ST_RESET) begin
        r_next.ir = CODE_IDCODE; // RULE13
        r_next.bs_lat[OE_BIT] = 1'b1; // RULE23
      end
    end
    // output moves only on falling edges, floating outside shift states
    if (ev.fall) begin // RULE5
      if (r_reg.state == ST_SHIFT_DR || r_reg.state == ST_SHIFT_IR) begin
        r_next.tdo = ser_out;
        r_next.oe_n = 1'b0; // RULE8
      end else begin
        r_next.tdo = 1'b0;
        r_next.oe_n = 1'b1;
      end
    end
  end

  // power-up reset puts the controller in its reset state; the memory core never sees it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin // RULE4 RULE11 RULE10
      r_reg.state <= ST_RESET;
      r_reg.ir_sh <= '0;
      r_reg.ir <= CODE_IDCODE; // RULE13
      r_reg.byp <= 1'b0;
      r_reg.id_sh <= '0;
      r_reg.bs_sh <= '0;
      r_reg.bs_lat <= LAT_RST; // RULE23
      r_reg.tdo <= 1'b0;
      r_reg.oe_n <= 1'b1; // RULE11
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs to the test pin and the pin ring
  // ----------------------------------------
  assign tdo_o = r_reg.tdo;
  assign tdo_oe_n = r_reg.oe_n;
  assign ring_out = r_reg.bs_lat;
  assign ring_drive = (r_reg.ir == CODE_EXTEST);
  // under external test the enable cell gates the bus; sample-z floats it outright
  assign qbus_float = (r_reg.ir == CODE_SAMPLE_Z) || // RULE21
                      ((r_reg.ir == CODE_EXTEST) && !r_reg.bs_lat[OE_BIT]); // RULE23
endmodule // scan_tap
`default_nettype wire

// ===== scan_tap_properties.sv
// port checker for the boundary-scan test port
`default_nettype none
module scan_tap_properties #(
  parameter int CHAIN = 109,
  parameter int OE_BIT = 108
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe_n,
  input wire logic [CHAIN-1:0] ring_in,
  input wire logic [CHAIN-1:0] ring_out,
  input wire logic ring_drive,
  input wire logic qbus_float
);
  timeunit 1ns;
  timeprecision 100ps;
  // counts test clock rises with mode select high; seen two edges before the port sees them
  logic tck_reg;
  logic [2:0] hi_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_reg <= 1'b0;
      hi_reg <= 3'h0;
    end else begin
      tck_reg <= tck;
      if (tck && !tck_reg) hi_reg <= !tms ? 3'h0 : (hi_reg == 3'h5 ? hi_reg : hi_reg + 3'h1);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property ($rose(rst_n) |-> tdo_oe_n && !ring_drive && !qbus_float && ring_out[OE_BIT])
    else $error("port not quiet after reset");
  a_idle_zero: assert property (tdo_oe_n |-> !tdo_o)
    else $error("data out not zero while released");
  a_out_on_fall: assert property (($changed(tdo_o) || $changed(tdo_oe_n)) |-> !$past(tck, 3))
    else $error("data out moved away from a falling edge");
  a_data_quiet: assert property ($changed(tdo_o) |-> !tdo_oe_n || $changed(tdo_oe_n))
    else $error("data out toggled while released");
  a_ir_on_rise: assert property ($changed(ring_drive) |-> $past(tck, 2))
    else $error("instruction changed away from a rising edge");
  a_latch_on_rise: assert property ($changed(ring_out) |-> $past(tck, 2))
    else $error("ring latches changed away from a rising edge");
  a_bus_gate: assert property (ring_drive |-> qbus_float == !ring_out[OE_BIT])
    else $error("bus gate does not follow its cell");
  a_five_reset: assert property ($rose(hi_reg == 3'h5) |-> ##[1:4] (ring_out[OE_BIT] && !ring_drive && !qbus_float))
    else $error("five high mode edges did not reset");
endmodule // scan_tap_properties
bind scan_tap scan_tap_properties #(.CHAIN(CHAIN), .OE_BIT(OE_BIT)) i_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .ring_in(ring_in), .ring_out(ring_out),
  .ring_drive(ring_drive), .qbus_float(qbus_float));
`default_nettype wire

// ===== scan_tap_tb_top.sv
// self-checking bench for the boundary-scan test port
`default_nettype none
module scan_tap_tb_top;
  import scan_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [CHAIN_LEN-1:0] ring_in = '0;
  logic [CHAIN_LEN-1:0] ring_out;
  logic tck, tms, tdi, tdo_o, tdo_oe_n, ring_drive, qbus_float;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  scan_tap i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe_n(tdo_oe_n), .ring_in(ring_in), .ring_out(ring_out), .ring_drive(ring_drive), .qbus_float(qbus_float));
  scan_ctl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n));
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  // idle to shift state, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic q, oe, oe_any;
    dout = '0;
    oe_any = 1'b0;
    i_ctl.step(1'b1, 1'b1, q, oe);
    if (ir) i_ctl.step(1'b1, 1'b1, q, oe);
    i_ctl.step(1'b0, 1'b1, q, oe);
    i_ctl.step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++) begin
      i_ctl.step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_any = oe_any | oe;
    end
    i_ctl.step(1'b1, 1'b1, q, oe);
    i_ctl.step(1'b0, 1'b1, q, oe);
    chk("enable while shifting", 128'h0, 128'(oe_any));
    chk("enable after shifting", 128'h1, 128'(oe));
  endtask
  task automatic tap_reset();
    logic q, oe;
    repeat (5) i_ctl.step(1'b1, 1'b1, q, oe);
    i_ctl.step(1'b0, 1'b1, q, oe);
  endtask
  task automatic t_power();
    chk("outputs after power-up", 128'h9, 128'({tdo_oe_n, ring_drive, qbus_float, ring_out[OE_CELL]}));
    $display("power-up test done");
  endtask
  task automatic t_bypass_reset();
    logic [127:0] d;
    tap_reset();
    scan(1'b1, IR_W, 128'(OP_BYPASS), d);
    chk("captured instruction", 128'(IR_CAPTURE), 128'(d[1:0]));
    scan(1'b0, 4, 128'hB, d);
    chk("bypass path", 128'h6, d);
    tap_reset();
    scan(1'b0, ID_W, 128'h0, d);
    chk("identification code", 128'(ID_VALUE), d);
    $display("bypass and reset test done");
  endtask
  task automatic t_boundary();
    logic [127:0] d;
    logic [CHAIN_LEN-1:0] p;
    logic [CHAIN_LEN-1:0] n;
    p = CHAIN_LEN'({4{32'hC3A5_0F96}});
    n = {1'b0, 108'h5_6789_ABCD_EF01_2345_6789_ABCD};
    @(posedge sys_clk);
    #1 ring_in = p;
    scan(1'b1, IR_W, 128'(OP_SAMPLE), d);
    chk("sample leaves bus", 128'h0, 128'({ring_drive, qbus_float}));
    scan(1'b0, CHAIN_LEN, 128'(n), d);
    chk("captured ring", 128'(p), d);
    chk("preload latches", 128'(n), 128'(ring_out));
    scan(1'b1, IR_W, 128'(OP_EXTEST), d);
    chk("external test gate", 128'h3, 128'({ring_drive, qbus_float}));
    scan(1'b1, IR_W, 128'(OP_SAMPLE_Z), d);
    chk("sample-z float", 128'h1, 128'({ring_drive, qbus_float}));
    tap_reset();
    chk("gate cell preset", 128'h1, 128'({ring_drive, qbus_float, ring_out[OE_CELL]}));
    $display("boundary test done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // the tests need about 3400 cycles; a hang is cut well beyond that
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_power();
    t_bypass_reset();
    t_boundary();
    summarize();
  end
endmodule // scan_tap_tb_top
`default_nettype wire
